// ### design/pdr_clk_cfg.sv
// Purpose: PLL prescale, feedback divisor, doze interlock and RC trim registers
// Assumes: AHB-Lite single word transfers, zero wait states, always OKAY
// Notes: Outputs are registered; they follow a write one cycle after its data phase
`timescale 1ns/100ps
`default_nettype none
module pdr_clk_cfg
    import pdr_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic irq_event,
    output logic [5:0] prescale_factor,
    output logic [9:0] pll_multiplier,
    output logic [5:0] rc_trim_value,
    output logic signed [11:0] rc_trim_dev,
    output logic [2:0] doze_ratio,
    output logic doze_enable
);
    // Register select decode, shared by read and write paths
    function automatic logic [1:0] reg_sel(input logic [31:0] a);
        logic [1:0] s;
        s = 2'h0;
        if (a[31:8] == 24'h000000) begin
            case (a[7:0])
                PDR_OFS_CLOCK_DIVISOR_REGISTER: s = 2'h1;
                PDR_OFS_FBDIV: s = 2'h2;
                PDR_OFS_TRIM: s = 2'h3;
                default: s = 2'h0;
            endcase
        end
        return s;
    endfunction

    // Bus address phase capture
    logic wr_pend_r, wr_pend_nxt;
    logic [1:0] wr_sel_r, wr_sel_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic addr_ok;

    // Configuration fields
    logic [4:0] pre_r, pre_nxt;
    logic [2:0] doze_r, doze_nxt;
    logic doze_enable_r, doze_enable_nxt;
    logic roi_r, roi_nxt;
    logic [8:0] fb_r, fb_nxt;
    logic [5:0] trim_r, trim_nxt;

    // Registered divider controls
    logic [5:0] pre_fac_r;
    logic [9:0] fb_fac_r;
    logic signed [11:0] dev_r;
    logic [5:0] pre_fac_c;
    logic [9:0] fb_fac_c;
    logic signed [11:0] dev_c;

    assign addr_ok = hsel && hready && (htrans == PDR_HTRANS_NONSEQ) && (hsize == PDR_HSIZE_WORD);

    always_comb begin
        pre_nxt = pre_r;
        doze_nxt = doze_r;
        doze_enable_nxt = doze_enable_r;
        roi_nxt = roi_r;
        fb_nxt = fb_r;
        trim_nxt = trim_r;
        if (wr_pend_r) begin
            case (wr_sel_r)
                2'h1: begin
                    pre_nxt = hwdata[PDR_POS_PRE_LO +: PDR_W_PRE];
                    roi_nxt = hwdata[PDR_POS_ROI];
                    if (!doze_enable_r) begin
                        doze_nxt = hwdata[PDR_POS_DOZE_LO +: PDR_W_DOZE];
                    end
                    if (!hwdata[PDR_POS_DOZE_ENABLE]) begin
                        doze_enable_nxt = 1'b0;
                    end else if (doze_nxt != 3'h0) begin
                        doze_enable_nxt = 1'b1;
                    end
                end
                2'h2: fb_nxt = hwdata[PDR_W_FB-1:0];
                2'h3: trim_nxt = hwdata[PDR_W_TRIM-1:0];
                default: begin
                end
            endcase
        end
        // Wake event wins over a simultaneous software set
        if (irq_event && roi_r) begin
            doze_enable_nxt = 1'b0;
        end
    end

    always_comb begin
        wr_pend_nxt = addr_ok && hwrite;
        wr_sel_nxt = addr_ok ? reg_sel(haddr) : 2'h0;
        rdata_nxt = 32'h00000000;
        // Read mux uses next values so read-after-write returns fresh data
        if (addr_ok && !hwrite) begin
            case (reg_sel(haddr))
                2'h1: begin
                    rdata_nxt[PDR_POS_ROI] = roi_nxt;
                    rdata_nxt[PDR_POS_DOZE_LO +: PDR_W_DOZE] = doze_nxt;
                    rdata_nxt[PDR_POS_DOZE_ENABLE] = doze_enable_nxt;
                    rdata_nxt[PDR_POS_PRE_LO +: PDR_W_PRE] = pre_nxt;
                end
                2'h2: rdata_nxt[PDR_W_FB-1:0] = fb_nxt;
                2'h3: rdata_nxt[PDR_W_TRIM-1:0] = trim_nxt;
                default: rdata_nxt = 32'h00000000;
            endcase
        end
    end

    pdr_ratio_map u_map (
        .pre_field(pre_nxt),
        .fb_field(fb_nxt),
        .trim_field(trim_nxt),
        .pre_factor(pre_fac_c),
        .fb_factor(fb_fac_c),
        .trim_dev(dev_c)
    );

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            wr_pend_r <= 1'b0;
            wr_sel_r <= 2'h0;
            rdata_r <= 32'h00000000;
            pre_r <= PDR_RST_PRE;
            doze_r <= PDR_RST_DOZE;
            doze_enable_r <= PDR_RST_DOZE_ENABLE;
            roi_r <= PDR_RST_ROI;
            fb_r <= PDR_RST_FB;
            trim_r <= PDR_RST_TRIM;
            pre_fac_r <= 6'({1'b0, PDR_RST_PRE}) + PDR_PRE_ADD;
            fb_fac_r <= 10'({1'b0, PDR_RST_FB}) + PDR_FB_ADD;
            dev_r <= 12'sh000;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            wr_sel_r <= wr_sel_nxt;
            rdata_r <= rdata_nxt;
            pre_r <= pre_nxt;
            doze_r <= doze_nxt;
            doze_enable_r <= doze_enable_nxt;
            roi_r <= roi_nxt;
            fb_r <= fb_nxt;
            trim_r <= trim_nxt;
            pre_fac_r <= pre_fac_c;
            fb_fac_r <= fb_fac_c;
            dev_r <= dev_c;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_r;
    assign prescale_factor = pre_fac_r;
    assign pll_multiplier = fb_fac_r;
    assign rc_trim_value = trim_r;
    assign rc_trim_dev = dev_r;
    assign doze_ratio = doze_r;
    assign doze_enable = doze_enable_r;

    property p_pre_factor;
        @(posedge mclk) disable iff (!rstn) prescale_factor == 6'({1'b0, pre_r}) + 6'h02;
    endproperty
    a_pre_factor: assert property (p_pre_factor) else $error("prescale factor mismatch");

    property p_doze_locked;
        @(posedge mclk) disable iff (!rstn) doze_enable_r |=> doze_r == $past(doze_r);
    endproperty
    a_doze_locked: assert property (p_doze_locked) else $error("doze ratio changed while enabled");

    property p_roi_clear;
        @(posedge mclk) disable iff (!rstn) (irq_event && roi_r) |=> !doze_enable_r;
    endproperty
    a_roi_clear: assert property (p_roi_clear) else $error("doze enable not cleared on interrupt");

    property p_doze_enable_needs_ratio;
        @(posedge mclk) disable iff (!rstn) $rose(doze_enable_r) |-> doze_r != 3'h0;
    endproperty
    a_doze_enable_needs_ratio: assert property (p_doze_enable_needs_ratio) else $error("doze enabled with zero ratio");

    property p_mult;
        @(posedge mclk) disable iff (!rstn) pll_multiplier == 10'({1'b0, fb_r}) + 10'h002;
    endproperty
    a_mult: assert property (p_mult) else $error("multiplier mismatch");

    property p_mult_reset;
        @(posedge mclk) !rstn |=> pll_multiplier == 10'h032;
    endproperty
    a_mult_reset: assert property (p_mult_reset) else $error("multiplier reset not 50");

    property p_trim_sign;
        @(posedge mclk) disable iff (!rstn)
            (trim_r == 6'h00) ? (rc_trim_dev == 12'sh000) :
            (trim_r[5] ? (rc_trim_dev < 12'sh000) : (rc_trim_dev > 12'sh000));
    endproperty
    a_trim_sign: assert property (p_trim_sign) else $error("trim deviation sign wrong");

    property p_trim_top;
        @(posedge mclk) disable iff (!rstn) trim_r == 6'h1F |-> rc_trim_dev == 12'sd1457;
    endproperty
    a_trim_top: assert property (p_trim_top) else $error("top trim deviation wrong");

    property p_trim_bottom;
        @(posedge mclk) disable iff (!rstn) trim_r == 6'h20 |-> rc_trim_dev == -12'sd1504;
    endproperty
    a_trim_bottom: assert property (p_trim_bottom) else $error("bottom trim deviation wrong");

    property p_fb_upper_zero;
        @(posedge mclk) disable iff (!rstn)
            (addr_ok && !hwrite && haddr == 32'({24'h000000, PDR_OFS_FBDIV})) |=> hrdata[31:9] == 23'h000000;
    endproperty
    a_fb_upper_zero: assert property (p_fb_upper_zero) else $error("feedback upper bits not zero");

    property p_fb_write;
        @(posedge mclk) disable iff (!rstn)
            (wr_pend_r && wr_sel_r == 2'h2) |=> pll_multiplier == 10'({1'b0, $past(hwdata[8:0])}) + 10'h002;
    endproperty
    a_fb_write: assert property (p_fb_write) else $error("feedback write not applied");

    c_doze_set: cover property (@(posedge mclk) disable iff (!rstn) $rose(doze_enable_r));
    c_roi_wake: cover property (@(posedge mclk) disable iff (!rstn) irq_event && roi_r && doze_enable_r);
    c_trim_neg: cover property (@(posedge mclk) disable iff (!rstn) trim_r == 6'h20);
    c_fb_max: cover property (@(posedge mclk) disable iff (!rstn) fb_r == 9'h1FF);
endmodule
`default_nettype wire

// ### design/pdr_pkg.sv
// Purpose: Shared constants for the PLL divider and RC trim configuration block
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes: Offsets are byte addresses within the block's window
package pdr_pkg;
    // Register byte offsets
    localparam logic [7:0] PDR_OFS_CLOCK_DIVISOR_REGISTER = 8'h00;
    localparam logic [7:0] PDR_OFS_FBDIV = 8'h04;
    localparam logic [7:0] PDR_OFS_TRIM = 8'h08;

    // Clock divisor register field positions
    localparam int PDR_POS_ROI = 15;
    localparam int PDR_POS_DOZE_LO = 12;
    localparam int PDR_POS_DOZE_ENABLE = 11;
    localparam int PDR_POS_PRE_LO = 0;

    // Field widths
    localparam int PDR_W_PRE = 5;
    localparam int PDR_W_DOZE = 3;
    localparam int PDR_W_FB = 9;
    localparam int PDR_W_TRIM = 6;

    // Values after reset
    localparam logic [4:0] PDR_RST_PRE = 5'h00;
    localparam logic [2:0] PDR_RST_DOZE = 3'h3;
    localparam logic PDR_RST_DOZE_ENABLE = 1'b0;
    localparam logic PDR_RST_ROI = 1'b0;
    localparam logic [8:0] PDR_RST_FB = 9'h030;
    localparam logic [5:0] PDR_RST_TRIM = 6'h00;

    // Field codes offset to divide and multiply factors
    localparam logic [5:0] PDR_PRE_ADD = 6'h02;
    localparam logic [9:0] PDR_FB_ADD = 10'h002;
    // Trim step in thousandths of a percent
    localparam logic signed [11:0] PDR_TRIM_STEP = 12'sh02F;

    // AHB-Lite encodings
    localparam logic [1:0] PDR_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] PDR_HSIZE_WORD = 3'h2;
endpackage

// ### design/pdr_ratio_map.sv
// Purpose: Maps stored divider and trim fields to factor values
// Assumes: Purely combinational, registered by the caller
// Notes: Trim deviation is in thousandths of a percent
`timescale 1ns/100ps
`default_nettype none
module pdr_ratio_map
    import pdr_pkg::*;
(
    input wire logic [4:0] pre_field,
    input wire logic [8:0] fb_field,
    input wire logic [5:0] trim_field,
    output logic [5:0] pre_factor,
    output logic [9:0] fb_factor,
    output logic signed [11:0] trim_dev
);
    always_comb begin
        pre_factor = 6'({1'b0, pre_field}) + PDR_PRE_ADD;
        fb_factor = 10'({1'b0, fb_field}) + PDR_FB_ADD;
        trim_dev = 12'($signed(trim_field)) * PDR_TRIM_STEP;
    end
endmodule
`default_nettype wire

// ### sim/pdr_bench.sv
// Purpose: Self-checking bench for the PLL divider and RC trim register block
// Assumes: Zero-wait AHB-Lite slave; outputs follow one cycle after data phase
// Notes: Random codes from a fixed seed, corner codes first
`timescale 1ns/100ps
`default_nettype none
module pll_divider_and_rc_tuning_bench
    import pdr_pkg::*;
;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic irq_event = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [5:0] prescale_factor;
    logic [9:0] pll_multiplier;
    logic [5:0] rc_trim_value;
    logic signed [11:0] rc_trim_dev;
    logic [2:0] doze_ratio;
    logic doze_enable;
    int error_cnt = 0;
    int checks_done = 0;
    logic [31:0] rd;
    logic [31:0] v;
    logic [31:0] corner [4] = '{32'hFFFFFFFF, 32'h00000000, 32'h0000001F, 32'h00000020};

    pdr_clk_cfg u_pdr_clk_cfg (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .irq_event(irq_event), .prescale_factor(prescale_factor),
        .pll_multiplier(pll_multiplier), .rc_trim_value(rc_trim_value), .rc_trim_dev(rc_trim_dev),
        .doze_ratio(doze_ratio), .doze_enable(doze_enable));

    initial begin
        forever #2 mclk = ~mclk;
    end

    // Two's-complement code times 47 thousandths of a percent
    function automatic logic signed [11:0] exp_dev(input logic [5:0] c);
        int k;
        k = c[5] ? int'(c) - 64 : int'(c);
        return 12'(k * 47);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // One single word transfer, address phase then data phase
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rdv);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= PDR_HTRANS_NONSEQ;
        hsize <= PDR_HSIZE_WORD;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rdv = hrdata;
        #1;
    endtask

    task automatic irq_pulse();
        @(posedge mclk);
        irq_event <= 1'b1;
        @(posedge mclk);
        irq_event <= 1'b0;
        #1;
    endtask

    task automatic final_report();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #40000;
        error_cnt++;
        final_report();
    end

    initial begin
        v = $urandom(71);
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        #1;
        chk(prescale_factor, 32'h2, "pre reset");
        chk(pll_multiplier, 32'h32, "mul reset");
        chk(rc_trim_value, 32'h0, "trim reset");
        chk(rc_trim_dev, 32'h0, "dev reset");
        chk(doze_enable, 32'h0, "doze en reset");
        bus(1'b0, PDR_OFS_FBDIV, 32'h0, rd);
        chk(rd, 32'h30, "fb read reset");
        bus(1'b0, PDR_OFS_CLOCK_DIVISOR_REGISTER, 32'h0, rd);
        chk(rd, 32'h3000, "clock_divisor_register read reset");
        for (int i = 0; i < 40; i++) begin
            v = (i < 4) ? corner[i] : $urandom;
            bus(1'b1, PDR_OFS_FBDIV, v, rd);
            chk(pll_multiplier, {22'h0, v[8:0]} + 32'h2, "mul");
            bus(1'b1, PDR_OFS_TRIM, v, rd);
            chk(rc_trim_value, v[5:0], "trim");
            chk(rc_trim_dev, exp_dev(v[5:0]), "dev");
            bus(1'b1, PDR_OFS_CLOCK_DIVISOR_REGISTER, v & 32'h1F, rd);
            chk(prescale_factor, {27'h0, v[4:0]} + 32'h2, "pre");
            bus(1'b0, PDR_OFS_FBDIV, 32'h0, rd);
            chk(rd, v & 32'h1FF, "fb read");
            bus(1'b0, PDR_OFS_TRIM, 32'h0, rd);
            chk(rd, v & 32'h3F, "trim read");
        end
        bus(1'b1, 32'h0C, 32'hFFFFFFFF, rd);
        bus(1'b0, 32'h0C, 32'h0, rd);
        chk(rd, 32'h0, "unmapped read");
        chk(hresp, 32'h0, "unmapped okay");
        bus(1'b1, PDR_OFS_CLOCK_DIVISOR_REGISTER, 32'h5800, rd);
        chk({doze_enable, doze_ratio}, 32'hD, "doze set");
        bus(1'b1, PDR_OFS_CLOCK_DIVISOR_REGISTER, 32'h2800, rd);
        chk(doze_ratio, 32'h5, "ratio locked");
        bus(1'b1, PDR_OFS_CLOCK_DIVISOR_REGISTER, 32'h0, rd);
        chk({doze_enable, doze_ratio}, 32'h5, "ratio locked on clear");
        bus(1'b1, PDR_OFS_CLOCK_DIVISOR_REGISTER, 32'h0, rd);
        bus(1'b1, PDR_OFS_CLOCK_DIVISOR_REGISTER, 32'h0800, rd);
        chk(doze_enable, 32'h0, "set with zero ratio");
        bus(1'b1, PDR_OFS_CLOCK_DIVISOR_REGISTER, 32'hC800, rd);
        chk(doze_enable, 32'h1, "doze set roi");
        irq_pulse();
        chk(doze_enable, 32'h0, "irq clears");
        bus(1'b1, PDR_OFS_CLOCK_DIVISOR_REGISTER, 32'h4800, rd);
        irq_pulse();
        chk(doze_enable, 32'h1, "irq without roi");
        bus(1'b0, PDR_OFS_CLOCK_DIVISOR_REGISTER, 32'h0, rd);
        chk(rd, 32'h4800, "clock_divisor_register read");
        final_report();
    end
endmodule
`default_nettype wire
